// >>> csfc_top.sv
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
`include "csfc_regs.svh"
module csfc_top
  import csfc_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [31:0] regRdata,
  input wire csfc_caps_t cardCaps,
  input wire logic wideCardPresent,
  input wire logic socketIdle,
  input wire logic hostClockStopping,
  output csfc_status_force_t statusForce,
  output csfc_event_force_t eventForce,
  output logic retestStrobe,
  output logic powerCtrlEnabled,
  output logic [2:0] cardSupplyOut,
  output logic [2:0] programSupplyOut,
  output logic badSupplyRequestSet,
  output logic cardClockStopAllowed
);
  if (ADDR_W < 5) begin : g_addr_check
    $error("csfc_top: ADDR_W too small for the register map");
  end

  csfc_state_t stReg;
  csfc_state_t stNext;
  logic forceWr;
  logic ctrlWr;
  logic ctrlRd;
  logic capsForced;
  logic retestWr;
  logic cardAllowed;
  logic programAllowed;
  logic [2:0] wrVcc;

  // Decode of the two mapped words; every other address reads zero.
  assign forceWr = regWrite &&
                   (regAddr == ADDR_W'(`CSFC_OFS_FORCE));
  assign ctrlWr = regWrite &&
                  (regAddr == ADDR_W'(`CSFC_OFS_CTRL));
  assign ctrlRd = regRead &&
                  (regAddr == ADDR_W'(`CSFC_OFS_CTRL));
  assign wrVcc = regWdata[`CSFC_F_VCC_HI:`CSFC_F_VCC_LO];
  assign retestWr = forceWr && regWdata[`CSFC_B_RETEST];
  assign capsForced = forceWr &&
                      (regWdata[`CSFC_B_YY:`CSFC_B_FIVE] != 4'h0);

  // Override writes reach the status and event registers in the write
  // cycle itself, so these strobes are combinational.
  always_comb begin
    statusForce.write = forceWr;
    statusForce.caps.yyVoltCapable = regWdata[`CSFC_B_YY];
    statusForce.caps.xxVoltCapable = regWdata[`CSFC_B_XX];
    statusForce.caps.threeVoltCapable = regWdata[`CSFC_B_THREE];
    statusForce.caps.fiveVoltCapable = regWdata[`CSFC_B_FIVE];
    statusForce.badSupplyRequestFlag = regWdata[`CSFC_B_BAD];
    statusForce.lostWriteFlag = regWdata[`CSFC_B_LOST];
    statusForce.unknownCardFlag = regWdata[`CSFC_B_UNKNOWN];
    statusForce.wideCardFlag = regWdata[`CSFC_B_WIDE];
    statusForce.narrowCardFlag = regWdata[`CSFC_B_NARROW];
    eventForce.write = forceWr;
    eventForce.powerChangeEvent = regWdata[`CSFC_B_PWR];
    eventForce.detectTwoEvent = regWdata[`CSFC_B_DET2];
    eventForce.detectOneEvent = regWdata[`CSFC_B_DET1];
    eventForce.statusChangeEvent = regWdata[`CSFC_B_STS];
  end

  assign retestStrobe = retestWr;

  csfc_supply_decode u_decode (
    .cardCode(stReg.cardSupplyRequest),
    .programCode(stReg.programSupplyRequest),
    .caps(cardCaps),
    .wideCard(wideCardPresent),
    .cardAllowed(cardAllowed),
    .programAllowed(programAllowed)
  );

  csfc_clkstop_gate u_clkstop (
    .clk(clk),
    .resetn(resetn),
    .socketIdle(socketIdle),
    .hostClockStopping(hostClockStopping),
    .clockStopPolicy(stReg.clockStopPolicy),
    .stopAllowed(cardClockStopAllowed)
  );

  always_comb begin
    stNext = stReg;
    stNext.readData = '0;
    stNext.badReqPulse = 1'b0;
    if (ctrlWr) begin
      // Only bits 7 to 4 and 2 to 0 are stored; the rest is dropped.
      stNext.clockStopPolicy = regWdata[`CSFC_B_POLICY];
      stNext.cardSupplyRequest = wrVcc;
      stNext.programSupplyRequest =
        regWdata[`CSFC_F_VPP_HI:`CSFC_F_VPP_LO];
      stNext.badReqPulse = !vccCodeKnown(wrVcc) ||
        (wideCardPresent && !vccFitsCaps(wrVcc, cardCaps));
    end
    // A retest in the same write as forced capabilities wins, since the
    // fresh interrogation replaces the forced values.
    if (capsForced) begin
      stNext.powerCtrlDisabled = 1'b1;
    end
    if (retestWr) begin
      stNext.powerCtrlDisabled = 1'b0;
    end
    // While power control is disabled the switch keeps its last setting.
    if (!stReg.powerCtrlDisabled) begin
      stNext.cardSupplyOut = cardAllowed ?
        stReg.cardSupplyRequest : `CSFC_V_OFF;
      stNext.programSupplyOut = programAllowed ?
        stReg.programSupplyRequest : `CSFC_V_OFF;
    end
    // The override word is write only and reads all zero.
    if (ctrlRd) begin
      stNext.readData[`CSFC_B_POLICY] = stReg.clockStopPolicy;
      stNext.readData[`CSFC_F_VCC_HI:`CSFC_F_VCC_LO] =
        stReg.cardSupplyRequest;
      stNext.readData[`CSFC_F_VPP_HI:`CSFC_F_VPP_LO] =
        stReg.programSupplyRequest;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      stReg <= '0;
    end else begin
      stReg <= stNext;
    end
  end

  assign regRdata = stReg.readData;
  assign powerCtrlEnabled = !stReg.powerCtrlDisabled;
  assign cardSupplyOut = stReg.cardSupplyOut;
  assign programSupplyOut = stReg.programSupplyOut;
  assign badSupplyRequestSet = stReg.badReqPulse;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  sequence s_force_read;
    regRead && (regAddr == ADDR_W'(`CSFC_OFS_FORCE));
  endsequence

  sequence s_ctrl_write;
    ctrlWr;
  endsequence

  sequence s_ctrl_read;
    ctrlRd && !regWrite;
  endsequence

  property p_force_read_zero;
    s_force_read |=> (regRdata == 32'h00000000);
  endproperty
  a_force_read_zero: assert property (p_force_read_zero)
    else $error("override register read not zero");

  property p_ctrl_upper_zero;
    regRead |=> ((regRdata & ~`CSFC_CTRL_MASK) == 32'h00000000);
  endproperty
  a_ctrl_upper_zero: assert property (p_ctrl_upper_zero)
    else $error("reserved control bits read nonzero");

  property p_ctrl_readback;
    s_ctrl_write ##1 s_ctrl_read |=>
      (regRdata == ($past(regWdata, 2) & `CSFC_CTRL_MASK));
  endproperty
  a_ctrl_readback: assert property (p_ctrl_readback)
    else $error("control word readback mismatch");

  property p_retest_enables;
    retestWr |=> powerCtrlEnabled;
  endproperty
  a_retest_enables: assert property (p_retest_enables)
    else $error("retest did not enable power control");

  property p_caps_disable;
    (capsForced && !retestWr) |=> !powerCtrlEnabled;
  endproperty
  a_caps_disable: assert property (p_caps_disable)
    else $error("forced capability left power control on");

  property p_disable_holds;
    (!powerCtrlEnabled && !retestWr) |=> !powerCtrlEnabled;
  endproperty
  a_disable_holds: assert property (p_disable_holds)
    else $error("power control re-enabled without retest");

  property p_frozen_supply;
    (!powerCtrlEnabled && !retestWr) |=> $stable(cardSupplyOut) &&
      $stable(programSupplyOut);
  endproperty
  a_frozen_supply: assert property (p_frozen_supply)
    else $error("supply changed while control disabled");

  property p_status_force;
    forceWr |-> statusForce.write &&
      (statusForce.caps == regWdata[`CSFC_B_YY:`CSFC_B_FIVE]) &&
      (statusForce.badSupplyRequestFlag == regWdata[`CSFC_B_BAD]) &&
      (statusForce.lostWriteFlag == regWdata[`CSFC_B_LOST]) &&
      (statusForce.unknownCardFlag == regWdata[`CSFC_B_UNKNOWN]) &&
      (statusForce.wideCardFlag == regWdata[`CSFC_B_WIDE]) &&
      (statusForce.narrowCardFlag == regWdata[`CSFC_B_NARROW]);
  endproperty
  a_status_force: assert property (p_status_force)
    else $error("status override does not follow write data");

  property p_event_force;
    forceWr |-> eventForce.write &&
      (eventForce.powerChangeEvent == regWdata[`CSFC_B_PWR]) &&
      (eventForce.detectTwoEvent == regWdata[`CSFC_B_DET2]) &&
      (eventForce.detectOneEvent == regWdata[`CSFC_B_DET1]) &&
      (eventForce.statusChangeEvent == regWdata[`CSFC_B_STS]);
  endproperty
  a_event_force: assert property (p_event_force)
    else $error("event override does not follow write data");

  property p_no_stray_force;
    !forceWr |-> !statusForce.write && !eventForce.write;
  endproperty
  a_no_stray_force: assert property (p_no_stray_force)
    else $error("override strobe without a write");

  property p_clock_stop;
    ##1 (cardClockStopAllowed == ($past(socketIdle) &&
      ($past(stReg.clockStopPolicy) || $past(hostClockStopping))));
  endproperty
  a_clock_stop: assert property (p_clock_stop)
    else $error("card clock stop permission wrong");

  property p_wide_safe;
    (wideCardPresent && powerCtrlEnabled &&
     !vccFitsCaps(stReg.cardSupplyRequest, cardCaps))
      |=> (cardSupplyOut == `CSFC_V_OFF);
  endproperty
  a_wide_safe: assert property (p_wide_safe)
    else $error("wide card powered at unacceptable voltage");

  property p_reserved_vpp_off;
    (powerCtrlEnabled && !vppCodeKnown(stReg.programSupplyRequest))
      |=> (programSupplyOut == `CSFC_V_OFF);
  endproperty
  a_reserved_vpp_off: assert property (p_reserved_vpp_off)
    else $error("reserved program supply code applied");

  property p_bad_request;
    (ctrlWr && wideCardPresent && !vccFitsCaps(wrVcc, cardCaps))
      |=> badSupplyRequestSet ##1
        (!badSupplyRequestSet || $past(ctrlWr));
  endproperty
  a_bad_request: assert property (p_bad_request)
    else $error("bad supply request not flagged for one cycle");

  property p_good_request;
    (ctrlWr && vccCodeKnown(wrVcc) && !wideCardPresent)
      |=> !badSupplyRequestSet;
  endproperty
  a_good_request: assert property (p_good_request)
    else $error("valid supply request flagged as bad");

  property p_read_idle_zero;
    !regRead |=> (regRdata == 32'h00000000);
  endproperty
  a_read_idle_zero: assert property (p_read_idle_zero)
    else $error("read data present without a read");

  property p_unmapped_read_zero;
    (regRead && !ctrlRd) |=> (regRdata == 32'h00000000);
  endproperty
  a_unmapped_read_zero: assert property (p_unmapped_read_zero)
    else $error("read of a non-control word not zero");

  property p_ctrl_hold;
    !ctrlWr |=> $stable(stReg.clockStopPolicy) &&
      $stable(stReg.cardSupplyRequest) &&
      $stable(stReg.programSupplyRequest);
  endproperty
  a_ctrl_hold: assert property (p_ctrl_hold)
    else $error("control word changed without a control write");

  sequence s_unknown_write;
    ctrlWr && !vccCodeKnown(wrVcc);
  endsequence

  property p_unknown_flagged;
    s_unknown_write |=> badSupplyRequestSet;
  endproperty
  a_unknown_flagged: assert property (p_unknown_flagged)
    else $error("reserved card supply code not flagged");

  property p_no_idle_flag;
    !ctrlWr |=> !badSupplyRequestSet;
  endproperty
  a_no_idle_flag: assert property (p_no_idle_flag)
    else $error("bad request flagged without a control write");

  property p_reserved_vcc_off;
    (powerCtrlEnabled && !vccCodeKnown(stReg.cardSupplyRequest))
      |=> (cardSupplyOut == `CSFC_V_OFF);
  endproperty
  a_reserved_vcc_off: assert property (p_reserved_vcc_off)
    else $error("reserved card supply code applied");

  sequence s_vcc_usable;
    powerCtrlEnabled && vccCodeKnown(stReg.cardSupplyRequest) &&
      (!wideCardPresent ||
       vccFitsCaps(stReg.cardSupplyRequest, cardCaps));
  endsequence

  property p_vcc_applied;
    s_vcc_usable |=> (cardSupplyOut == $past(stReg.cardSupplyRequest));
  endproperty
  a_vcc_applied: assert property (p_vcc_applied)
    else $error("valid card supply request not applied");

  property p_vpp_applied;
    (powerCtrlEnabled && vppCodeKnown(stReg.programSupplyRequest))
      |=> (programSupplyOut == $past(stReg.programSupplyRequest));
  endproperty
  a_vpp_applied: assert property (p_vpp_applied)
    else $error("valid program supply request not applied");

  property p_idle_needed;
    !socketIdle |=> !cardClockStopAllowed;
  endproperty
  a_idle_needed: assert property (p_idle_needed)
    else $error("card clock stop allowed while socket busy");

  property p_host_needed;
    (!stReg.clockStopPolicy && !hostClockStopping)
      |=> !cardClockStopAllowed;
  endproperty
  a_host_needed: assert property (p_host_needed)
    else $error("card clock stop allowed without host clock stop");
endmodule : csfc_top

// >>> csfc_regs.svh
`ifndef CSFC_REGS_SVH
`define CSFC_REGS_SVH
`define CSFC_OFS_FORCE 8'h0C
`define CSFC_OFS_CTRL 8'h10
`define CSFC_CTRL_RESET 32'h00000000
`define CSFC_CTRL_MASK 32'h000000F7
`define CSFC_B_RETEST 14
`define CSFC_B_YY 13
`define CSFC_B_XX 12
`define CSFC_B_THREE 11
`define CSFC_B_FIVE 10
`define CSFC_B_BAD 9
`define CSFC_B_LOST 8
`define CSFC_B_UNKNOWN 7
`define CSFC_B_WIDE 5
`define CSFC_B_NARROW 4
`define CSFC_B_PWR 3
`define CSFC_B_DET2 2
`define CSFC_B_DET1 1
`define CSFC_B_STS 0
`define CSFC_B_POLICY 7
`define CSFC_F_VCC_HI 6
`define CSFC_F_VCC_LO 4
`define CSFC_F_VPP_HI 2
`define CSFC_F_VPP_LO 0
`define CSFC_V_OFF 3'h0
`define CSFC_V_12V 3'h1
`define CSFC_V_5V 3'h2
`define CSFC_V_3V3 3'h3
`define CSFC_V_XX 3'h4
`define CSFC_V_YY 3'h5
`endif

// >>> csfc_pkg.sv
`include "csfc_regs.svh"
package csfc_pkg;
  typedef struct packed {
    logic yyVoltCapable;
    logic xxVoltCapable;
    logic threeVoltCapable;
    logic fiveVoltCapable;
  } csfc_caps_t;

  typedef struct packed {
    logic write;
    csfc_caps_t caps;
    logic badSupplyRequestFlag;
    logic lostWriteFlag;
    logic unknownCardFlag;
    logic wideCardFlag;
    logic narrowCardFlag;
  } csfc_status_force_t;

  typedef struct packed {
    logic write;
    logic powerChangeEvent;
    logic detectTwoEvent;
    logic detectOneEvent;
    logic statusChangeEvent;
  } csfc_event_force_t;

  typedef struct packed {
    logic [31:0] readData;
    logic clockStopPolicy;
    logic [2:0] cardSupplyRequest;
    logic [2:0] programSupplyRequest;
    logic powerCtrlDisabled;
    logic [2:0] cardSupplyOut;
    logic [2:0] programSupplyOut;
    logic badReqPulse;
  } csfc_state_t;

  // Card supply codes 001, 110 and 111 request nothing.
  function automatic logic vccCodeKnown(input logic [2:0] code);
    case (code)
      `CSFC_V_OFF, `CSFC_V_5V, `CSFC_V_3V3, `CSFC_V_XX, `CSFC_V_YY: begin
        vccCodeKnown = 1'b1;
      end
      default: begin
        vccCodeKnown = 1'b0;
      end
    endcase
  endfunction : vccCodeKnown

  function automatic logic vppCodeKnown(input logic [2:0] code);
    vppCodeKnown = (code <= `CSFC_V_YY);
  endfunction : vppCodeKnown

  function automatic logic vccFitsCaps(input logic [2:0] code,
                                       input csfc_caps_t caps);
    case (code)
      `CSFC_V_OFF: vccFitsCaps = 1'b1;
      `CSFC_V_5V: vccFitsCaps = caps.fiveVoltCapable;
      `CSFC_V_3V3: vccFitsCaps = caps.threeVoltCapable;
      `CSFC_V_XX: vccFitsCaps = caps.xxVoltCapable;
      `CSFC_V_YY: vccFitsCaps = caps.yyVoltCapable;
      default: vccFitsCaps = 1'b0;
    endcase
  endfunction : vccFitsCaps
endpackage : csfc_pkg

// >>> csfc_supply_decode.sv
`timescale 1ns/1ps
module csfc_supply_decode
  import csfc_pkg::*;
(
  input wire logic [2:0] cardCode,
  input wire logic [2:0] programCode,
  input wire csfc_caps_t caps,
  input wire logic wideCard,
  output logic cardAllowed,
  output logic programAllowed
);
  always_comb begin
    cardAllowed = vccCodeKnown(cardCode) &&
                  (!wideCard || vccFitsCaps(cardCode, caps));
    programAllowed = vppCodeKnown(programCode);
  end
endmodule : csfc_supply_decode

// >>> csfc_clkstop_gate.sv
`timescale 1ns/1ps
module csfc_clkstop_gate (
  input wire logic clk,
  input wire logic resetn,
  input wire logic socketIdle,
  input wire logic hostClockStopping,
  input wire logic clockStopPolicy,
  output logic stopAllowed
);
  logic stop_reg;
  logic stop_next;

  always_comb begin
    stop_next = socketIdle && (clockStopPolicy || hostClockStopping);
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      stop_reg <= 1'b0;
    end else begin
      stop_reg <= stop_next;
    end
  end

  assign stopAllowed = stop_reg;
endmodule : csfc_clkstop_gate

// >>> csfc_top_tb.sv
`timescale 1ns/1ps
`include "csfc_regs.svh"
module csfc_top_tb
  import csfc_pkg::*;
;
  logic clk;
  logic resetn;
  logic [7:0] regAddr;
  logic [31:0] regWdata;
  logic regWrite;
  logic regRead;
  logic [31:0] regRdata;
  csfc_caps_t cardCaps;
  logic wideCardPresent;
  logic socketIdle;
  logic hostClockStopping;
  csfc_status_force_t statusForce;
  csfc_event_force_t eventForce;
  logic retestStrobe;
  logic powerCtrlEnabled;
  logic [2:0] cardSupplyOut;
  logic [2:0] programSupplyOut;
  logic badSupplyRequestSet;
  logic cardClockStopAllowed;
  csfc_status_force_t sfSeen;
  csfc_event_force_t efSeen;
  logic rsSeen;
  logic [31:0] rdData;
  logic [31:0] w;
  logic [2:0] code;
  logic enExp;
  logic bad;
  int mismatches;
  int checks;

  csfc_top i_csfc_top (
    .clk(clk),
    .resetn(resetn),
    .regAddr(regAddr),
    .regWdata(regWdata),
    .regWrite(regWrite),
    .regRead(regRead),
    .regRdata(regRdata),
    .cardCaps(cardCaps),
    .wideCardPresent(wideCardPresent),
    .socketIdle(socketIdle),
    .hostClockStopping(hostClockStopping),
    .statusForce(statusForce),
    .eventForce(eventForce),
    .retestStrobe(retestStrobe),
    .powerCtrlEnabled(powerCtrlEnabled),
    .cardSupplyOut(cardSupplyOut),
    .programSupplyOut(programSupplyOut),
    .badSupplyRequestSet(badSupplyRequestSet),
    .cardClockStopAllowed(cardClockStopAllowed)
  );

  initial begin
    clk = 1'b0;
  end

  always begin
    #2.5 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_of_test

  // Captures the combinational override strobes inside the write cycle.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    #1;
    sfSeen = statusForce;
    efSeen = eventForce;
    rsSeen = retestStrobe;
    @(posedge clk);
    regWrite <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    #1;
    d = regRdata;
  endtask : rd

  function automatic logic fitsCaps(input logic [2:0] c);
    case (c)
      3'h0: fitsCaps = 1'b1;
      3'h2: fitsCaps = cardCaps.fiveVoltCapable;
      3'h3: fitsCaps = cardCaps.threeVoltCapable;
      3'h4: fitsCaps = cardCaps.xxVoltCapable;
      3'h5: fitsCaps = cardCaps.yyVoltCapable;
      default: fitsCaps = 1'b0;
    endcase
  endfunction : fitsCaps

  initial begin
    repeat (2000) @(posedge clk);
    mismatches++;
    end_of_test();
  end

  initial begin
    resetn = 1'b0;
    regAddr = 8'h00;
    regWdata = 32'h0;
    regWrite = 1'b0;
    regRead = 1'b0;
    cardCaps = 4'h5;
    wideCardPresent = 1'b0;
    socketIdle = 1'b0;
    hostClockStopping = 1'b0;
    mismatches = 0;
    checks = 0;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    #1;
    check(32'(powerCtrlEnabled), 32'h1);
    check(32'(cardSupplyOut), 32'h0);
    check(32'(programSupplyOut), 32'h0);
    check(32'(cardClockStopAllowed), 32'h0);
    rd(`CSFC_OFS_CTRL, rdData);
    check(rdData, 32'h00000000);
    rd(`CSFC_OFS_FORCE, rdData);
    check(rdData, 32'h00000000);
    $display("test reset values done");

    wr(`CSFC_OFS_CTRL, 32'hFFFFFFFF);
    check(32'(sfSeen.write), 32'h0);
    rd(`CSFC_OFS_CTRL, rdData);
    check(rdData, 32'h000000F7);
    @(posedge clk);
    #1;
    check(regRdata, 32'h0);
    wr(8'h14, 32'hFFFFFFFF);
    rd(8'h14, rdData);
    check(rdData, 32'h0);
    rd(`CSFC_OFS_CTRL, rdData);
    check(rdData, 32'h000000F7);
    @(posedge clk);
    regAddr <= `CSFC_OFS_CTRL;
    regWdata <= 32'h000000A5;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    #1;
    check(regRdata, 32'h000000A5);
    $display("test control access done");

    enExp = 1'b1;
    for (int i = 0; i < 32; i++) begin
      w = 32'h1 << i;
      wr(`CSFC_OFS_FORCE, w);
      if (w[14]) begin
        enExp = 1'b1;
      end else if (|w[13:10]) begin
        enExp = 1'b0;
      end
      check(32'(sfSeen), 32'({1'b1, w[13:7], w[5:4]}));
      check(32'(efSeen), 32'({1'b1, w[3:0]}));
      check(32'(rsSeen), 32'(w[14]));
      check(32'(powerCtrlEnabled), 32'(enExp));
    end
    wr(`CSFC_OFS_FORCE, 32'hFFFFFFFF);
    check(32'(sfSeen), 32'h000003FF);
    check(32'(powerCtrlEnabled), 32'h1);
    rd(`CSFC_OFS_FORCE, rdData);
    check(rdData, 32'h0);
    $display("test override strobes done");

    for (int wide = 0; wide < 2; wide++) begin
      @(posedge clk);
      wideCardPresent <= wide[0];
      for (int i = 0; i < 8; i++) begin
        code = i[2:0];
        wr(`CSFC_OFS_CTRL, (32'(code) << 4) | 32'(code));
        bad = !(code inside {3'h0, 3'h2, 3'h3, 3'h4, 3'h5}) ||
              (wide[0] && !fitsCaps(code));
        check(32'(badSupplyRequestSet), 32'(bad));
        @(posedge clk);
        #1;
        check(32'(badSupplyRequestSet), 32'h0);
        check(32'(cardSupplyOut), bad ? 32'h0 : 32'(code));
        check(32'(programSupplyOut), code <= 3'h5 ? 32'(code) : 32'h0);
      end
    end
    wr(`CSFC_OFS_CTRL, 32'h00000022);
    wr(`CSFC_OFS_FORCE, 32'h00000400);
    check(32'(powerCtrlEnabled), 32'h0);
    wr(`CSFC_OFS_CTRL, 32'h00000033);
    repeat (2) @(posedge clk);
    #1;
    check(32'(cardSupplyOut), 32'h2);
    check(32'(programSupplyOut), 32'h2);
    wr(`CSFC_OFS_FORCE, 32'h00004000);
    check(32'(powerCtrlEnabled), 32'h1);
    $display("test supply requests done");

    for (int k = 0; k < 8; k++) begin
      wr(`CSFC_OFS_CTRL, 32'(k[2]) << 7);
      @(posedge clk);
      socketIdle <= k[1];
      hostClockStopping <= k[0];
      repeat (2) @(posedge clk);
      #1;
      check(32'(cardClockStopAllowed), 32'(k[1] && (k[2] || k[0])));
    end
    $display("test clock stop policy done");
    end_of_test();
  end
endmodule : csfc_top_tb
